// [design/link_pkg.sv]
// shared constants and types for the daisy-chain link ends
package link_pkg;
  // ----------------------------------------------------------------
  // chain and character sizes
  // ----------------------------------------------------------------
  localparam int          MAX_DEVICES = 32;
  localparam int          ADDR_W      = 5;
  localparam int          BYTE_W      = 8;
  localparam logic [7:0]  PEC_SEED    = 8'hA5;
  // ----------------------------------------------------------------
  // command codes (first character of a packet)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_WRITE       = 8'h02;
  localparam logic [7:0]  CMD_BCAST_WRITE = 8'h03;
  localparam logic [7:0]  CMD_READ        = 8'h04;
  localparam logic [7:0]  CMD_CLAIM_UPPER = 8'h08;
  localparam logic [7:0]  CMD_CLAIM_LOWER = 8'h09;
  // ----------------------------------------------------------------
  // device register selects and status field layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_LINK_CFG     = 8'h10;
  localparam logic [7:0]  REG_STATUS       = 8'h11;
  localparam int          STAT_CFG_LSB     = 0;
  localparam int          STAT_UART_BIT    = 2;
  localparam int          STAT_MASTER_BIT  = 3;
  localparam int          STAT_MISROUTE_BIT = 4;
  localparam int          MISROUTE_CLR_BIT = 0;
  localparam logic [7:0]  IDLE_BYTE        = 8'h00;
  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CFG_EXT_LOOP = 2'b00,
    CFG_INT_LOOP = 2'b01,
    CFG_ALERT    = 2'b10,
    CFG_DUAL     = 2'b11
  } link_cfg_type;
  localparam link_cfg_type LINK_CFG_RESET = CFG_EXT_LOOP;
  typedef enum logic [2:0] {
    POS_CMD  = 3'b000,
    POS_ADDR = 3'b001,
    POS_REG  = 3'b010,
    POS_DATA = 3'b011,
    POS_PEC  = 3'b100
  } pkt_pos_type;
  typedef enum logic [0:0] {
    HOST_IDLE = 1'b0,
    HOST_SEND = 1'b1
  } host_state_type;
endpackage : link_pkg

// [design/chain_link_if.sv]
// character-level link between the host controller end and a chain device
`timescale 1ns/100ps
interface chain_link_if;
  import link_pkg::*;
  logic       rxl_valid;
  logic [7:0] rxl_data;
  logic       txl_valid;
  logic [7:0] txl_data;
  logic       txu_valid;
  logic [7:0] txu_data;
  logic       rxu_valid;
  logic [7:0] rxu_data;
  logic       alert_p;
  logic       alert_n;
  modport dev (
    input  rxl_valid, rxl_data, rxu_valid, rxu_data,
    output txl_valid, txl_data, txu_valid, txu_data, alert_p, alert_n
  );
  modport host (
    output rxl_valid, rxl_data, rxu_valid, rxu_data,
    input  txl_valid, txl_data, txu_valid, txu_data, alert_p, alert_n
  );
endinterface : chain_link_if

// [design/chain_device.sv]
// chain device: up/down path forwarding, link mode and master routing
`timescale 1ns/100ps
module chain_device (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_sel,
  input  wire logic [4:0]   i_dev_addr,
  input  wire logic         i_alert,
  chain_link_if.dev         link,
  output logic              o_uart_mode,
  output link_pkg::link_cfg_type o_link_cfg,
  output logic              o_master_lower,
  output logic              o_misroute
);
  import link_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  sel_done;
    logic                  uart_on;
    link_cfg_type          cfg;
    logic                  master_lower;
    logic                  misroute;
    pkt_pos_type [1:0]     pos;
    logic [1:0][7:0]       cmd;
    logic [1:0]            hit;
    logic [1:0][7:0]       rsel;
    logic [1:0][7:0]       data;
    logic [1:0][7:0]       pec_in;
    logic [1:0][7:0]       pec_out;
    logic [1:0]            swapped;
    logic [1:0]            tx_valid;
    logic [1:0][7:0]       tx_data;
    logic                  alert_p;
    logic                  alert_n;
  } dev_state_type;

  dev_state_type q;
  dev_state_type d;

  logic [1:0]       in_v;
  logic [1:0][7:0]  in_d;
  logic [1:0]       live;
  logic [1:0]       master;
  logic [7:0]       status;
  logic [7:0]       outb;
  logic             set_mis;
  logic             clr_mis;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    set_mis = 1'b0;
    clr_mis = 1'b0;
    outb    = IDLE_BYTE;
    // strap caught once after reset, then frozen
    if (!q.sel_done) begin
      d.sel_done = 1'b1;
      d.uart_on  = i_sel;
    end
    // path 0 is the up path, path 1 the down path
    in_v[0] = q.uart_on & link.rxl_valid;
    in_d[0] = link.rxl_data;
    // internal loop takes our own upper transmit; pins ignored
    if (q.cfg == CFG_INT_LOOP) begin
      in_v[1] = q.uart_on & q.tx_valid[0];
      in_d[1] = q.tx_data[0];
    end else begin
      in_v[1] = q.uart_on & link.rxu_valid;
      in_d[1] = link.rxu_data;
    end
    // down port carries the alert level instead of characters
    if (q.cfg == CFG_ALERT) begin
      in_v[1] = 1'b0;
    end
    d.alert_p = (q.cfg == CFG_ALERT) & i_alert;
    d.alert_n = (q.cfg == CFG_ALERT) & ~i_alert;
    // down path only acts in dual mode
    live[0]   = 1'b1;
    live[1]   = (q.cfg == CFG_DUAL);
    master[0] = (q.cfg != CFG_DUAL) | ~q.master_lower;
    master[1] = (q.cfg == CFG_DUAL) & q.master_lower;
    status = IDLE_BYTE;
    status[STAT_CFG_LSB +: 2]   = q.cfg;
    status[STAT_UART_BIT]       = q.uart_on;
    status[STAT_MASTER_BIT]     = q.master_lower;
    status[STAT_MISROUTE_BIT]   = q.misroute;
    for (int p = 0; p < 2; p++) begin
      d.tx_valid[p] = 1'b0;
      d.tx_data[p]  = IDLE_BYTE;
      if (in_v[p]) begin
        outb = in_d[p];
        case (q.pos[p])
          POS_CMD: begin
            d.cmd[p]     = in_d[p];
            d.pec_in[p]  = PEC_SEED ^ in_d[p];
            d.swapped[p] = 1'b0;
            d.pos[p]     = POS_ADDR;
          end
          POS_ADDR: begin
            d.hit[p]    = (in_d[p][ADDR_W-1:0] == i_dev_addr);
            d.pec_in[p] = q.pec_in[p] ^ in_d[p];
            d.pos[p]    = POS_REG;
          end
          POS_REG: begin
            d.rsel[p]   = in_d[p];
            d.pec_in[p] = q.pec_in[p] ^ in_d[p];
            d.pos[p]    = POS_DATA;
          end
          POS_DATA: begin
            d.data[p]   = in_d[p];
            d.pec_in[p] = q.pec_in[p] ^ in_d[p];
            // addressed read: our register replaces the data field
            if (live[p] && q.cmd[p] == CMD_READ && q.hit[p]) begin
              outb         = (q.rsel[p] == REG_LINK_CFG) ? {6'h00, q.cfg} : status;
              d.swapped[p] = 1'b1;
            end
            d.pos[p] = POS_PEC;
          end
          POS_PEC: begin
            d.pos[p] = POS_CMD;
            if (q.swapped[p]) begin
              outb = q.pec_out[p];
            end
            // nothing executes until the whole packet checks good
            if (in_d[p] == q.pec_in[p] && live[p]) begin
              case (q.cmd[p])
                CMD_WRITE, CMD_BCAST_WRITE: begin
                  if (!master[p]) begin
                    set_mis = 1'b1;
                  end else if (q.cmd[p] == CMD_BCAST_WRITE || q.hit[p]) begin
                    if (q.rsel[p] == REG_LINK_CFG) begin
                      d.cfg = link_cfg_type'(q.data[p][1:0]);
                    end
                    if (q.rsel[p] == REG_STATUS && q.data[p][MISROUTE_CLR_BIT]) begin
                      clr_mis = 1'b1;
                    end
                  end
                end
                CMD_CLAIM_UPPER: begin
                  if (p == 0) begin
                    d.master_lower = 1'b0;
                  end else begin
                    set_mis = 1'b1;
                  end
                end
                CMD_CLAIM_LOWER: begin
                  if (p == 1) begin
                    d.master_lower = 1'b1;
                  end else begin
                    set_mis = 1'b1;
                  end
                end
                default: begin
                end
              endcase
            end
          end
          default: begin
            d.pos[p] = POS_CMD;
          end
        endcase
        // every character goes straight on, one cycle later
        d.tx_valid[p] = 1'b1;
        d.tx_data[p]  = outb;
        if (q.pos[p] == POS_CMD) begin
          d.pec_out[p] = PEC_SEED ^ outb;
        end else begin
          d.pec_out[p] = q.pec_out[p] ^ outb;
        end
      end
    end
    // a new misroute wins over a clear in the same cycle
    d.misroute = set_mis | (q.misroute & ~clr_mis);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q          <= '0;
      q.cfg      <= LINK_CFG_RESET;
    end else begin
      q <= d;
    end
  end

  assign link.txu_valid = q.tx_valid[0];
  assign link.txu_data  = q.tx_data[0];
  assign link.txl_valid = q.tx_valid[1];
  assign link.txl_data  = q.tx_data[1];
  assign link.alert_p   = q.alert_p;
  assign link.alert_n   = q.alert_n;
  assign o_uart_mode    = q.uart_on;
  assign o_link_cfg     = q.cfg;
  assign o_master_lower = q.master_lower;
  assign o_misroute     = q.misroute;
endmodule : chain_device

// [design/chain_host.sv]
// host controller end: packet sender, receive collector, top loop cable
`timescale 1ns/100ps
module chain_host (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_req_valid,
  input  wire logic [7:0]   i_req_cmd,
  input  wire logic [4:0]   i_req_addr,
  input  wire logic [7:0]   i_req_reg,
  input  wire logic [7:0]   i_req_data,
  input  wire logic         i_req_lower,
  input  wire logic         i_loop_cable,
  input  wire logic         i_flush,
  chain_link_if.host        link,
  output logic              o_req_ready,
  output logic              o_rsp_valid,
  output logic [7:0]        o_rsp_cmd,
  output logic [7:0]        o_rsp_addr,
  output logic [7:0]        o_rsp_reg,
  output logic [7:0]        o_rsp_data,
  output logic              o_rsp_pec_ok
);
  import link_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    host_state_type    st;
    pkt_pos_type       tpos;
    logic [3:0][7:0]   pkt;
    logic [7:0]        tpec;
    logic              lower;
    logic              cfg_wr;
    logic              again;
    logic              ready;
    logic              txl_v;
    logic              txu_v;
    logic [7:0]        tx_d;
    pkt_pos_type       rpos;
    logic [3:0][7:0]   rbuf;
    logic [7:0]        rpec;
    logic              rsp_v;
    logic [3:0][7:0]   rsp;
    logic              rsp_ok;
  } host_state_pack_type;

  host_state_pack_type q;
  host_state_pack_type d;
  logic       rv;
  logic [7:0] rd;
  logic       flush;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    flush   = i_flush;
    d.rsp_v = 1'b0;
    d.txl_v = 1'b0;
    d.txu_v = 1'b0;
    d.tx_d  = IDLE_BYTE;
    case (q.st)
      HOST_IDLE: begin
        // only the host ever starts a packet
        if (i_req_valid && q.ready) begin
          d.pkt    = {i_req_data, i_req_reg, {3'b000, i_req_addr}, i_req_cmd};
          d.lower  = i_req_lower;
          d.cfg_wr = (i_req_cmd == CMD_WRITE || i_req_cmd == CMD_BCAST_WRITE)
                     && i_req_reg == REG_LINK_CFG;
          d.again  = (i_req_data[1:0] == CFG_INT_LOOP);
          d.st     = HOST_SEND;
          d.tpos   = POS_CMD;
          d.ready  = 1'b0;
          if (d.cfg_wr) begin
            flush = 1'b1;
          end
        end else begin
          d.ready = 1'b1;
        end
      end
      HOST_SEND: begin
        d.txl_v = ~q.lower;
        d.txu_v = q.lower;
        case (q.tpos)
          POS_CMD: begin
            d.tx_d = q.pkt[0];
            d.tpec = PEC_SEED ^ q.pkt[0];
            d.tpos = POS_ADDR;
          end
          POS_ADDR, POS_REG, POS_DATA: begin
            d.tx_d = q.pkt[q.tpos[1:0]];
            d.tpec = q.tpec ^ q.pkt[q.tpos[1:0]];
            d.tpos = pkt_pos_type'(q.tpos + 3'b001);
          end
          default: begin
            d.tx_d = q.tpec;
            d.tpos = POS_CMD;
            // an internal-loop write is cut on its way back: send it twice
            if (q.cfg_wr && q.again) begin
              d.again = 1'b0;
            end else begin
              d.st = HOST_IDLE;
            end
            if (q.cfg_wr) begin
              flush = 1'b1;
            end
          end
        endcase
      end
      default: begin
        d.st = HOST_IDLE;
      end
    endcase
    // returning characters; the lower port has priority
    rv = link.txl_valid | (link.txu_valid & ~i_loop_cable);
    rd = link.txl_valid ? link.txl_data : link.txu_data;
    if (flush) begin
      d.rpos = POS_CMD;
    end else if (rv) begin
      if (q.rpos == POS_PEC) begin
        // a good answer from each step tells where the chain breaks
        d.rsp_v  = 1'b1;
        d.rsp    = q.rbuf;
        d.rsp_ok = (rd == q.rpec);
        d.rpos   = POS_CMD;
      end else begin
        d.rbuf[q.rpos[1:0]] = rd;
        d.rpec = (q.rpos == POS_CMD) ? (PEC_SEED ^ rd) : (q.rpec ^ rd);
        d.rpos = pkt_pos_type'(q.rpos + 3'b001);
      end
    end
  end

  // ----------------------------------------------------------------
  // registers and link drive
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // the cable echoes upper transmit back into upper receive
  logic       cab_v_q;
  logic [7:0] cab_d_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cab_v_q <= 1'b0;
      cab_d_q <= IDLE_BYTE;
    end else begin
      cab_v_q <= (i_loop_cable & link.txu_valid) | d.txu_v;
      cab_d_q <= d.txu_v ? d.tx_d : link.txu_data;
    end
  end

  assign link.rxl_valid = q.txl_v;
  assign link.rxl_data  = q.txl_v ? q.tx_d : IDLE_BYTE;
  assign link.rxu_valid = cab_v_q;
  assign link.rxu_data  = cab_d_q;
  assign o_req_ready    = q.ready;
  assign o_rsp_valid    = q.rsp_v;
  assign o_rsp_cmd      = q.rsp[0];
  assign o_rsp_addr     = q.rsp[1];
  assign o_rsp_reg      = q.rsp[2];
  assign o_rsp_data     = q.rsp[3];
  assign o_rsp_pec_ok   = q.rsp_ok;
endmodule : chain_host

// [testbench/chain_link_props.sv]
// checker: timing relations on the link between host end and chain device
`timescale 1ns/100ps
module chain_link_props (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       rxl_valid,
  input  wire logic [7:0] rxl_data,
  input  wire logic       txl_valid,
  input  wire logic [7:0] txl_data,
  input  wire logic       txu_valid,
  input  wire logic [7:0] txu_data,
  input  wire logic       rxu_valid,
  input  wire logic [7:0] rxu_data,
  input  wire logic       alert_p,
  input  wire logic       alert_n
);
  // ----------------------------------------------------------------
  // clocking and packet sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // looser than a closed run: a paired config write may arrive back to back
  sequence host_run;
    rxl_valid [*5];
  endsequence
  sequence up_run;
    txu_valid [*5];
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_UP_FWD: assert property (rxl_valid |=> txu_valid)
    else $error("up char not forwarded next cycle");
  AST_UP_ONLY_FWD: assert property (txu_valid |-> $past(rxl_valid))
    else $error("upper transmit without lower receive");
  AST_CMD_COPY: assert property ($rose(txu_valid) |-> txu_data == $past(rxl_data))
    else $error("command char changed on up path");
  AST_UP_WHOLE: assert property ($rose(txu_valid) |-> up_run)
    else $error("up packet cut short");
  AST_HOST_WHOLE: assert property ($rose(rxl_valid) |-> host_run)
    else $error("host packet cut short");
  AST_DOWN_SRC: assert property (txl_valid |-> $past(rxu_valid) || $past(rxl_valid, 2))
    else $error("lower transmit without a source");
  AST_ALERT_QUIET: assert property ((alert_p || alert_n) |-> !txl_valid)
    else $error("down traffic while alert drives port");
  AST_ALERT_DIFF: assert property (!(alert_p && alert_n))
    else $error("alert pair not differential");
endmodule : chain_link_props

// [testbench/tb.sv]
// testbench: host end and chain device joined, plus a raw-driven second device
`timescale 1ns/100ps
module tb;
  import link_pkg::*;
  logic         i_clk, i_rst_n, req_valid, req_lower, loop_cable, flush, alert, sel2;
  logic [7:0]   req_cmd, req_reg, req_data, rsp_cmd, rsp_addr, rsp_reg, rsp_data;
  logic [4:0]   req_addr, dst;
  logic         req_ready, rsp_valid, rsp_pec_ok, uart_mode, master_lower, misroute, uart_mode2;
  link_cfg_type link_cfg, link_cfg2;
  int           mismatches, n_tests;
  chain_link_if link ();
  chain_link_if link2 ();
  // ----------------------------------------------------------------
  // design ends and checker
  // ----------------------------------------------------------------
  chain_device i_chain_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sel(1'b1), .i_dev_addr(5'h03),
    .i_alert(alert), .link(link), .o_uart_mode(uart_mode), .o_link_cfg(link_cfg),
    .o_master_lower(master_lower), .o_misroute(misroute));
  chain_host i_chain_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(req_valid), .i_req_cmd(req_cmd),
    .i_req_addr(req_addr), .i_req_reg(req_reg), .i_req_data(req_data), .i_req_lower(req_lower),
    .i_loop_cable(loop_cable), .i_flush(flush), .link(link), .o_req_ready(req_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_cmd(rsp_cmd), .o_rsp_addr(rsp_addr), .o_rsp_reg(rsp_reg),
    .o_rsp_data(rsp_data), .o_rsp_pec_ok(rsp_pec_ok));
  // second device faces a raw driver that may send a corrupt packet
  chain_device i_chain_device_2 (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sel(sel2), .i_dev_addr(5'h01),
    .i_alert(1'b0), .link(link2), .o_uart_mode(uart_mode2), .o_link_cfg(link_cfg2),
    .o_master_lower(), .o_misroute());
  assign link2.rxu_valid = 1'b0;
  assign link2.rxu_data  = 8'h00;
  chain_link_props i_chain_link_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .rxl_valid(link.rxl_valid),
    .rxl_data(link.rxl_data), .txl_valid(link.txl_valid), .txl_data(link.txl_data),
    .txu_valid(link.txu_valid), .txu_data(link.txu_data), .rxu_valid(link.rxu_valid),
    .rxu_data(link.rxu_data), .alert_p(link.alert_p), .alert_n(link.alert_n));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bump(inout int k);
    k++;
    if (k > 80) begin
      mismatches++;
      final_report();
    end
  endtask : bump
  task automatic send(input logic [7:0] c, input logic [7:0] r, input logic [7:0] d, input logic lo);
    int k;
    k = 0;
    @(negedge i_clk);
    while (req_ready !== 1'b1) begin
      bump(k);
      @(negedge i_clk);
    end
    @(posedge i_clk);
    req_valid <= 1'b1;
    req_cmd   <= c;
    req_reg   <= r;
    req_data  <= d;
    req_lower <= lo;
    req_addr  <= dst;
    @(posedge i_clk);
    req_valid <= 1'b0;
  endtask : send
  // answer data of a forwarded write is the written byte itself
  task automatic xact(input logic [7:0] c, input logic [7:0] r, input logic [7:0] d, input logic lo,
                      input logic [7:0] exp);
    int k;
    k = 0;
    send(c, r, d, lo);
    @(negedge i_clk);
    while (rsp_valid !== 1'b1) begin
      bump(k);
      @(negedge i_clk);
    end
    chk(rsp_data, exp);
    chk({7'h00, rsp_pec_ok}, 8'h01);
    chk(rsp_cmd, c);
    chk(rsp_addr, {3'b000, dst});
    chk(rsp_reg, r);
  endtask : xact
  // config writes flush the collector as their check char leaves: no answer can complete
  task automatic quiet(input logic [7:0] c, input logic [7:0] r, input logic [7:0] d, input logic lo,
                       input logic [7:0] exp);
    int seen;
    seen = 0;
    send(c, r, d, lo);
    for (int i = 0; i < 24; i++) begin
      @(negedge i_clk);
      if (rsp_valid === 1'b1) begin
        seen++;
      end
    end
    chk(seen[7:0], 8'h00);
    chk({6'h00, link_cfg}, exp);
  endtask : quiet
  task automatic flush_rx();
    @(posedge i_clk);
    flush <= 1'b1;
    @(posedge i_clk);
    flush <= 1'b0;
  endtask : flush_rx
  task automatic raw(input logic [7:0] r, input logic [7:0] d, input logic bad);
    logic [7:0] b [5];
    b[0] = CMD_WRITE;
    b[1] = 8'h01;
    b[2] = r;
    b[3] = d;
    b[4] = PEC_SEED ^ b[0] ^ b[1] ^ r ^ d ^ {7'h00, bad};
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clk);
      link2.rxl_valid <= 1'b1;
      link2.rxl_data  <= b[i];
    end
    @(posedge i_clk);
    link2.rxl_valid <= 1'b0;
    link2.rxl_data  <= ~b[4];
    repeat (3) @(posedge i_clk);
  endtask : raw
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = 8'h00;
    req_addr = 5'h03;
    dst = 5'h03;
    req_reg = 8'h00;
    req_data = 8'h00;
    req_lower = 1'b0;
    loop_cable = 1'b1;
    flush = 1'b0;
    alert = 1'b0;
    sel2 = 1'b1;
    link2.rxl_valid = 1'b0;
    link2.rxl_data = 8'h00;
    mismatches = 0;
    n_tests = 0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    sel2 <= 1'b0;
    chk({7'h00, uart_mode}, 8'h01);
    chk({6'h00, link_cfg}, 8'h00);
    xact(CMD_READ, REG_STATUS, 8'h00, 1'b0, 8'h04);
    dst = 5'h04;
    xact(CMD_READ, REG_STATUS, 8'h5A, 1'b0, 8'h5A);
    dst = 5'h03;
    quiet(CMD_WRITE, REG_LINK_CFG, 8'h03, 1'b1, 8'h00);
    chk({6'h00, link_cfg}, 8'h00);
    chk({7'h00, misroute}, 8'h00);
    // cable off in dual mode, else every up write echoes onto the slave path
    loop_cable <= 1'b0;
    flush_rx();
    quiet(CMD_WRITE, REG_LINK_CFG, 8'h03, 1'b0, 8'h03);
    flush_rx();
    chk({6'h00, link_cfg}, 8'h03);
    xact(CMD_WRITE, REG_STATUS, 8'h00, 1'b1, 8'h00);
    chk({7'h00, misroute}, 8'h01);
    xact(CMD_READ, REG_STATUS, 8'h00, 1'b1, 8'h17);
    xact(CMD_WRITE, REG_STATUS, 8'h01, 1'b0, 8'h01);
    xact(CMD_CLAIM_LOWER, REG_STATUS, 8'h00, 1'b0, 8'h00);
    chk({misroute, master_lower}, 8'h02);
    xact(CMD_CLAIM_LOWER, REG_STATUS, 8'h00, 1'b1, 8'h00);
    xact(CMD_READ, REG_STATUS, 8'h00, 1'b0, 8'h1F);
    xact(CMD_WRITE, REG_STATUS, 8'h01, 1'b1, 8'h01);
    chk({misroute, master_lower}, 8'h01);
    xact(CMD_CLAIM_UPPER, REG_STATUS, 8'h00, 1'b1, 8'h00);
    xact(CMD_CLAIM_UPPER, REG_STATUS, 8'h00, 1'b0, 8'h00);
    chk({misroute, master_lower}, 8'h02);
    dst = 5'h04;
    xact(CMD_BCAST_WRITE, REG_STATUS, 8'h01, 1'b0, 8'h01);
    dst = 5'h03;
    chk({misroute, master_lower}, 8'h00);
    xact(CMD_WRITE, REG_STATUS, 8'h01, 1'b0, 8'h01);
    flush_rx();
    quiet(CMD_WRITE, REG_LINK_CFG, 8'h02, 1'b0, 8'h02);
    flush_rx();
    alert <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({link.alert_p, link.alert_n}, 8'h02);
    xact(CMD_READ, REG_STATUS, 8'h00, 1'b0, 8'h06);
    loop_cable <= 1'b1;
    flush_rx();
    quiet(CMD_WRITE, REG_LINK_CFG, 8'h01, 1'b0, 8'h01);
    flush_rx();
    chk({6'h00, link_cfg}, 8'h01);
    xact(CMD_READ, REG_STATUS, 8'h00, 1'b0, 8'h05);
    // a read sent on the upper pins must vanish while the loop is internal
    quiet(CMD_READ, REG_STATUS, 8'h00, 1'b1, 8'h01);
    raw(REG_LINK_CFG, 8'h03, 1'b1);
    chk({6'h00, link_cfg2}, 8'h00);
    raw(REG_LINK_CFG, 8'h03, 1'b0);
    chk({6'h00, link_cfg2}, 8'h03);
    chk({7'h00, uart_mode2}, 8'h01);
    final_report();
  end
endmodule : tb
